// *** logic/dual_uart_pins.sv ***
// dual uart host parallel port, modem control pins and serial loop-back
// Operation
// - 8-bit three-state host bus; bit zero is first serial bit.
// - active-low data-set-ready sampled and shown in modem status register.
// - modem control bit 0 set drives terminal-ready low.
// - terminal-ready high after bit 0 cleared or any reset.
// - both channel interrupts merged onto one open-drain active-low output.
// - interrupt pulled low when any enabled source needs service.
// - strobe low in a selected access writes the addressed register.
// - strobe high in a selected access drives the addressed register out.
// - user output is the inverse of modem control bit 3.
// - both user outputs high after reset.
// - reset clears registers and bus outputs, drives modem outputs high, holds serial in and out idle.
// - ring-indicator rising edge raises an enabled modem status interrupt.
// - modem control bit 1 set drives request-to-send low.
// - both request-to-send outputs high after reset.
// - request-to-send follows receive flow only with automatic mode enabled.
// - loop-back ignores the receive pin and feeds transmit data inward.
// - loop-back disables the external transmit pin.
// - automatic mode drops request-to-send at halt, restores at resume level.
`timescale 1ns/100ps
module dual_uart_pins
  import dual_uart_pkg::*;
(
  // clock and reset
  input  wire logic                                MCLK,
  input  wire logic                                RESET_N,
  // host parallel port
  input  wire logic                                CS_N,
  input  wire logic                                RW,
  input  wire logic [dual_uart_pkg::ADDR_W-1:0]    ADDR,
  input  wire logic                                CHANNEL_SELECT_BIT,
  input  wire logic [dual_uart_pkg::DATA_W-1:0]    HOST_DATA_BUS_IN,
  output logic      [dual_uart_pkg::DATA_W-1:0]    HOST_DATA_BUS_OUT,
  output logic                                     HOST_DATA_BUS_OE,
  // shared interrupt, open drain
  output logic                                     IRQ_N_OUT,
  output logic                                     IRQ_N_OE,
  // modem status inputs, one bit per channel
  input  wire logic [dual_uart_pkg::NUM_CH-1:0]    DSR_N,
  input  wire logic [dual_uart_pkg::NUM_CH-1:0]    CTS_N,
  input  wire logic [dual_uart_pkg::NUM_CH-1:0]    CD_N,
  input  wire logic [dual_uart_pkg::NUM_CH-1:0]    RI_N,
  // modem control outputs
  output logic      [dual_uart_pkg::NUM_CH-1:0]    DTR_N,
  output logic      [dual_uart_pkg::NUM_CH-1:0]    RTS_N,
  output logic      [dual_uart_pkg::NUM_CH-1:0]    USER_OUTPUT,
  // serial data paths
  input  wire logic [dual_uart_pkg::NUM_CH-1:0]    TX_DATA,
  output logic      [dual_uart_pkg::NUM_CH-1:0]    TX_PIN,
  input  wire logic [dual_uart_pkg::NUM_CH-1:0]    RX_PIN,
  output logic      [dual_uart_pkg::NUM_CH-1:0]    RX_TO_RECEIVER,
  // receive fifo fill levels, channel 0 in the low bits
  input  wire logic [dual_uart_pkg::NUM_CH*dual_uart_pkg::LEVEL_W-1:0] RX_LEVEL
);
  import dual_uart_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] rst_sync_q;
  logic                   rst_n;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[SYNC_STAGES-1];

  // ----------------------------------------------------------------
  // host access sequencing
  // ----------------------------------------------------------------
  // one register action per chip-select assertion, so a long strobe
  // cannot clear read-sensitive flags twice
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_BUSY = 2'b10
  } acc_state_t;

  acc_state_t acc_q;
  acc_state_t acc_d;
  logic       start;
  logic       wr_start;
  logic       rd_start;

  assign start    = (acc_q == ACC_IDLE) && !CS_N;
  assign wr_start = start && !RW;
  assign rd_start = start && RW;

  always_comb begin
    acc_d = acc_q;
    unique case (acc_q)
      ACC_IDLE: begin
        if (!CS_N) begin
          acc_d = ACC_BUSY;
        end
      end
      ACC_BUSY: begin
        if (CS_N) begin
          acc_d = ACC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= ACC_IDLE;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------------------------------
  // per-channel registers and pins
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_word [NUM_CH];
  logic [NUM_CH-1:0] ch_irq;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [DATA_W-1:0]  scratch_q;
      logic [DATA_W-1:0]  int_enable_q;
      logic [DATA_W-1:0]  enhanced_feature_reg_q;
      logic [DATA_W-1:0]  modem_control_reg_q;
      logic [DATA_W-1:0]  flow_threshold_reg_q;
      logic [DATA_W-1:0]  modem_status_reg;
      logic               sel;
      logic               wr;
      logic               msr_clr;
      logic               pending;
      logic               halt_q;
      logic [LEVEL_W-1:0] level;
      logic [LEVEL_W-1:0] halt_lvl;
      logic [LEVEL_W-1:0] resume_lvl;
      logic               loop;
      logic               rts_on;

      assign sel     = (CHANNEL_SELECT_BIT == ch[0]);
      assign wr      = wr_start && sel;
      assign msr_clr = rd_start && sel && (ADDR == OFS_MSR);
      assign loop    = modem_control_reg_q[MCR_LOOP];
      assign level   = RX_LEVEL[ch*LEVEL_W +: LEVEL_W];

      // writable registers
      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          scratch_q              <= REG_RESET;
          int_enable_q           <= REG_RESET;
          enhanced_feature_reg_q <= REG_RESET;
          modem_control_reg_q    <= REG_RESET;
          flow_threshold_reg_q   <= REG_RESET;
        end else if (wr) begin
          unique case (ADDR)
            OFS_SCRATCH: scratch_q              <= HOST_DATA_BUS_IN;
            OFS_IER:     int_enable_q           <= HOST_DATA_BUS_IN;
            OFS_EFR:     enhanced_feature_reg_q <= HOST_DATA_BUS_IN;
            OFS_MCR:     modem_control_reg_q    <= HOST_DATA_BUS_IN;
            OFS_TCR:     flow_threshold_reg_q   <= HOST_DATA_BUS_IN;
            default:     ;
          endcase
        end
      end

      // modem status, change flags cleared by reading it
      modem_status_track u_msr (
        .clk      (MCLK),
        .rst_n    (rst_n),
        .cts_n    (CTS_N[ch]),
        .dsr_n    (DSR_N[ch]),
        .ri_n     (RI_N[ch]),
        .cd_n     (CD_N[ch]),
        .clr      (msr_clr),
        .status_q (modem_status_reg)
      );

      // only the modem source lives here, so any change flag interrupts
      assign pending = int_enable_q[IER_MODEM] && (|modem_status_reg[3:0]);
      assign ch_irq[ch] = pending;

      // read view of the channel
      always_comb begin
        unique case (ADDR)
          OFS_SCRATCH: rd_word[ch] = scratch_q;
          OFS_IER:     rd_word[ch] = int_enable_q;
          OFS_ISR:     rd_word[ch] = pending ? ISR_MODEM : ISR_NONE;
          OFS_EFR:     rd_word[ch] = enhanced_feature_reg_q;
          OFS_MCR:     rd_word[ch] = modem_control_reg_q;
          OFS_TCR:     rd_word[ch] = flow_threshold_reg_q;
          OFS_MSR:     rd_word[ch] = modem_status_reg;
          default:     rd_word[ch] = READ_UNMAP;
        endcase
      end

      // receive flow thresholds count in steps of four bytes
      assign halt_lvl = LEVEL_W'(flow_threshold_reg_q[TCR_HALT_LO +: TCR_NIB_W]) << TCR_SHIFT;
      assign resume_lvl = LEVEL_W'(flow_threshold_reg_q[TCR_RES_LO +: TCR_NIB_W]) << TCR_SHIFT;

      // hysteresis between halt and resume levels
      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          halt_q <= 1'b0;
        end else if (level >= halt_lvl) begin
          halt_q <= 1'b1;
        end else if (level <= resume_lvl) begin
          halt_q <= 1'b0;
        end
      end

      // modem control outputs, each held high through reset
      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          DTR_N[ch] <= 1'b1;
        end else begin
          DTR_N[ch] <= ~modem_control_reg_q[MCR_DTR];
        end
      end

      // automatic mode only withholds the request, never forces it
      assign rts_on = modem_control_reg_q[MCR_RTS]
                      && !(enhanced_feature_reg_q[EFR_AUTO_RTS] && halt_q);

      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          RTS_N[ch] <= 1'b1;
        end else begin
          RTS_N[ch] <= ~rts_on;
        end
      end

      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          USER_OUTPUT[ch] <= 1'b1;
        end else begin
          USER_OUTPUT[ch] <= ~modem_control_reg_q[MCR_USER];
        end
      end

      // serial paths; idle line is high, so a held-off pin reads as mark
      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          TX_PIN[ch] <= 1'b1;
        end else begin
          TX_PIN[ch] <= loop ? 1'b1 : TX_DATA[ch];
        end
      end

      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          RX_TO_RECEIVER[ch] <= 1'b1;
        end else begin
          RX_TO_RECEIVER[ch] <= loop ? TX_DATA[ch] : RX_PIN[ch];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // host data bus
  // ----------------------------------------------------------------
  // read data is frozen at the access start so a flag cleared by the
  // read is still seen by the host
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      HOST_DATA_BUS_OUT <= REG_RESET;
    end else if (rd_start) begin
      HOST_DATA_BUS_OUT <= rd_word[CHANNEL_SELECT_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      HOST_DATA_BUS_OE <= 1'b0;
    end else begin
      HOST_DATA_BUS_OE <= !CS_N && RW;
    end
  end

  // ----------------------------------------------------------------
  // shared interrupt
  // ----------------------------------------------------------------
  // pin is only ever pulled low; the board pull-up gives the high level
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_N_OUT <= 1'b0;
    end else begin
      IRQ_N_OUT <= 1'b0;
    end
  end

  // wired-or of both channels, one cycle behind the change flags
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_N_OE  <= 1'b0;
    end else begin
      IRQ_N_OE  <= |ch_irq;
    end
  end

endmodule // dual_uart_pins

// *** logic/dual_uart_pkg.sv ***
// constants for the dual uart host port and modem pin block
package dual_uart_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH      = 2;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 3;
  localparam int LEVEL_W     = 7;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // register offsets within one channel
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_SCRATCH = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_IER     = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_ISR     = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_EFR     = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_MCR     = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_TCR     = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_MSR     = 3'h6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MCR_DTR      = 0;
  localparam int MCR_RTS      = 1;
  localparam int MCR_USER     = 3;
  localparam int MCR_LOOP     = 4;
  localparam int EFR_AUTO_RTS = 6;
  localparam int IER_MODEM    = 3;
  localparam int TCR_HALT_LO  = 0;
  localparam int TCR_RES_LO   = 4;
  localparam int TCR_NIB_W    = 4;
  localparam int TCR_SHIFT    = 2;

  // ----------------------------------------------------------------
  // reset and read values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] ISR_NONE    = 8'h01;
  localparam logic [DATA_W-1:0] ISR_MODEM   = 8'h00;
  localparam logic [DATA_W-1:0] READ_UNMAP  = 8'h00;
  localparam logic [3:0]        PIN_IDLE_N  = 4'hf;

endpackage

// *** logic/modem_status_track.sv ***
// modem status register of one channel: pin levels and sticky change flags
`timescale 1ns/100ps
module modem_status_track (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // modem pins, active low
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       cd_n,
  // clear of the change flags on a host read
  input  wire logic       clr,
  // register image
  output logic [7:0]      status_q
);
  import dual_uart_pkg::*;
  logic [3:0] pins;
  logic [3:0] prev_q;
  logic [3:0] ev;
  logic [3:0] delta_d;

  // order in the image: cd, ri, dsr, cts
  assign pins = {cd_n, ri_n, dsr_n, cts_n};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= PIN_IDLE_N;
    end else begin
      prev_q <= pins;
    end
  end

  // ring flag only on the trailing edge of the ring, low to high
  assign ev = {prev_q[3] ^ pins[3],
               ~prev_q[2] & pins[2],
               prev_q[1] ^ pins[1],
               prev_q[0] ^ pins[0]};

  // set wins over a clear in the same cycle
  assign delta_d = (clr ? 4'h0 : status_q[3:0]) | ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= REG_RESET;
    end else begin
      status_q <= {~pins, delta_d};
    end
  end
endmodule // modem_status_track

// *** verif/dual_uart_assertions.sv ***
// concurrent checks on the dual uart host port and modem pins
`timescale 1ns/100ps
module dual_uart_assertions
  import dual_uart_pkg::*;
(
  // clock and reset
  input wire logic       MCLK,
  input wire logic       RESET_N,
  // host port
  input wire logic       CS_N,
  input wire logic       RW,
  input wire logic [2:0] ADDR,
  input wire logic       CHANNEL_SELECT_BIT,
  input wire logic [7:0] HOST_DATA_BUS_IN,
  input wire logic [7:0] HOST_DATA_BUS_OUT,
  input wire logic       HOST_DATA_BUS_OE,
  input wire logic       IRQ_N_OUT,
  input wire logic       IRQ_N_OE,
  // modem and serial pins
  input wire logic [1:0] DTR_N,
  input wire logic [1:0] RTS_N,
  input wire logic [1:0] USER_OUTPUT,
  input wire logic [1:0] TX_PIN,
  input wire logic [1:0] RX_PIN,
  input wire logic [1:0] RX_TO_RECEIVER
);
  logic cs_q;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  always_ff @(posedge MCLK) cs_q <= CS_N;
  // only the first low cycle of chip select starts an access
  wire rd_go  = !CS_N && RW && cs_q;
  wire rd_lvl = !CS_N && RW;
  sequence wr_go(logic [2:0] ofs);
    !CS_N && !RW && cs_q && ADDR == ofs;
  endsequence
  chk_dtr_from_mcr: assert property (wr_go(OFS_MCR) |-> ##2
    DTR_N[$past(CHANNEL_SELECT_BIT, 2)] == !$past(HOST_DATA_BUS_IN[MCR_DTR], 2))
    else $error("terminal ready wrong after control write");
  chk_user_from_mcr: assert property (wr_go(OFS_MCR) |-> ##2
    USER_OUTPUT[$past(CHANNEL_SELECT_BIT, 2)] == !$past(HOST_DATA_BUS_IN[MCR_USER], 2))
    else $error("user output wrong after control write");
  chk_oe_after_read: assert property (HOST_DATA_BUS_OE == $past(rd_lvl))
    else $error("bus enable not one cycle behind a read");
  chk_unmap_read_zero: assert property (rd_go && ADDR == 3'h7 |=>
    HOST_DATA_BUS_OUT == READ_UNMAP)
    else $error("unmapped offset read not zero");
  chk_read_data_holds: assert property (!$past(rd_go) |-> $stable(HOST_DATA_BUS_OUT))
    else $error("read data changed without a read");
  chk_irq_open_drain: assert property (IRQ_N_OE |-> !IRQ_N_OUT)
    else $error("interrupt pin driven high");
  chk_loop_tx_idle: assert property (
    ((RX_TO_RECEIVER ^ $past(RX_PIN)) & ~TX_PIN) == 2'h0)
    else $error("receiver fed inward while transmit pin active");
  chk_reset_outputs_idle: assert property ($rose(RESET_N) |->
    ({DTR_N, RTS_N, USER_OUTPUT, TX_PIN} == 8'hff && !HOST_DATA_BUS_OE && !IRQ_N_OE)[*2])
    else $error("outputs not idle while reset releases");
endmodule  // dual_uart_assertions

bind dual_uart_pins dual_uart_assertions u_chk (
  .MCLK(MCLK), .RESET_N(RESET_N), .CS_N(CS_N), .RW(RW), .ADDR(ADDR),
  .CHANNEL_SELECT_BIT(CHANNEL_SELECT_BIT), .HOST_DATA_BUS_IN(HOST_DATA_BUS_IN),
  .HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT), .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE),
  .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE), .DTR_N(DTR_N), .RTS_N(RTS_N),
  .USER_OUTPUT(USER_OUTPUT), .TX_PIN(TX_PIN), .RX_PIN(RX_PIN),
  .RX_TO_RECEIVER(RX_TO_RECEIVER)
);

// *** verif/host_bus_model.sv ***
// host cpu model: bus cycles plus data bus and interrupt wire levels
`timescale 1ns/100ps
module host_bus_model (
  // clock
  input  wire logic       clk,
  // host port of the uart
  output logic            cs_n,
  output logic            rw,
  output logic [2:0]      addr,
  output logic            chan,
  output logic [7:0]      din,
  input  wire logic [7:0] dout,
  input  wire logic       oe,
  // interrupt wire
  input  wire logic       irq_out,
  input  wire logic       irq_oe,
  output logic            irq_pin
);
  logic       drv = 1'b0;
  logic [7:0] dq  = 8'h00;
  // released bus shows the inverse so a stale value never matches
  assign din     = oe ? dout : (drv ? dq : ~dq);
  assign irq_pin = irq_oe ? irq_out : 1'b1;
  initial begin
    cs_n = 1'b1;
    rw   = 1'b1;
    addr = 3'h0;
    chan = 1'b0;
  end
  // held to the taking edge, then one idle cycle before the next
  task automatic access(input logic wr, input logic ch, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    chan = ch;
    rw   = !wr;
    addr = a;
    dq   = d;
    drv  = wr;
    @(posedge clk);
    #1;
    q    = dout;
    cs_n = 1'b1;
    drv  = 1'b0;
  endtask
endmodule  // host_bus_model

// *** verif/test_dual_uart_host_modem_pins.sv ***
// self-checking bench for the dual uart host port and modem pins
`timescale 1ns/100ps
module test_dual_uart_host_modem_pins;
  import dual_uart_pkg::*;
  logic        MCLK     = 1'b0;
  logic        RESET_N  = 1'b0;
  logic [1:0]  DSR_N    = 2'h3;
  logic [1:0]  CTS_N    = 2'h3;
  logic [1:0]  CD_N     = 2'h3;
  logic [1:0]  RI_N     = 2'h3;
  logic [1:0]  TX_DATA  = 2'h0;
  logic [1:0]  RX_PIN   = 2'h3;
  logic [13:0] RX_LEVEL = 14'h0;
  wire         CS_N, RW, CHAN, OE, IRQ_N_OUT, IRQ_N_OE, IRQ;
  wire  [2:0]  ADDR;
  wire  [7:0]  DIN, DOUT;
  wire  [1:0]  DTR_N, RTS_N, USER_OUTPUT, TX_PIN, RX_TO_RECEIVER;
  int          n_errors    = 0;
  int          comparisons = 0;
  always #2 MCLK = ~MCLK;
  dual_uart_pins u_dual_uart_pins (.MCLK(MCLK), .RESET_N(RESET_N), .CS_N(CS_N), .RW(RW),
    .ADDR(ADDR), .CHANNEL_SELECT_BIT(CHAN), .HOST_DATA_BUS_IN(DIN),
    .HOST_DATA_BUS_OUT(DOUT), .HOST_DATA_BUS_OE(OE), .IRQ_N_OUT(IRQ_N_OUT),
    .IRQ_N_OE(IRQ_N_OE), .DSR_N(DSR_N), .CTS_N(CTS_N), .CD_N(CD_N), .RI_N(RI_N),
    .DTR_N(DTR_N), .RTS_N(RTS_N), .USER_OUTPUT(USER_OUTPUT), .TX_DATA(TX_DATA),
    .TX_PIN(TX_PIN), .RX_PIN(RX_PIN), .RX_TO_RECEIVER(RX_TO_RECEIVER), .RX_LEVEL(RX_LEVEL));
  host_bus_model u_host (.clk(MCLK), .cs_n(CS_N), .rw(RW), .addr(ADDR), .chan(CHAN),
    .din(DIN), .dout(DOUT), .oe(OE), .irq_out(IRQ_N_OUT), .irq_oe(IRQ_N_OE), .irq_pin(IRQ));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.access(1'b1, ch, a, d, q);
  endtask
  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] q);
    u_host.access(1'b0, ch, a, 8'h00, q);
  endtask
  task automatic chk_reset();
    check({DTR_N, RTS_N, USER_OUTPUT, TX_PIN}, 8'hff);
    check({RX_TO_RECEIVER, OE, IRQ}, 4'hd);
    check(DOUT, 8'h00);
  endtask
  // loop-back forces the transmit pin high and feeds transmit data inward
  function automatic logic [4:0] mcr_pins(logic [7:0] m, logic tx, logic rx);
    return {m[4] | tx, m[4] ? tx : rx, !m[3], !m[1], !m[0]};
  endfunction
  function automatic logic [4:0] pins(logic c);
    return {TX_PIN[c], RX_TO_RECEIVER[c], USER_OUTPUT[c], RTS_N[c], DTR_N[c]};
  endfunction
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] q;
    logic [7:0] m;
    logic       c;
    logic [6:0] lv [5];
    lv = '{7'h14, 7'h0a, 7'h04, 7'h0f, 7'h10};
    void'($urandom(32'hd06ea7f4));
    RX_LEVEL[13:7] = 7'($urandom);
    tick(4);
    chk_reset();
    RESET_N = 1'b1;
    tick(3);
    for (int i = 0; i < 12; i++) begin
      c = i[0];
      m = 8'($urandom) & 8'h1b;
      TX_DATA = 2'($urandom);
      RX_PIN = 2'($urandom);
      wr(c, OFS_MCR, m);
      tick(2);
      check(pins(c), mcr_pins(m, TX_DATA[c], RX_PIN[c]));
      rd(c, OFS_MCR, q);
      check(q, m);
      m = 8'($urandom);
      wr(c, OFS_SCRATCH, m);
      rd(c, OFS_SCRATCH, q);
      check(q, m);
      rd(c, 3'h7, q);
      check(q, READ_UNMAP);
    end
    for (int i = 0; i < 6; i++) begin
      c = i[0];
      {DSR_N, CTS_N, CD_N} = 6'($urandom);
      tick(3);
      rd(c, OFS_MSR, q);
      check(q[7:4], {~CD_N[c], ~RI_N[c], ~DSR_N[c], ~CTS_N[c]});
    end
    // clear stale change flags before enabling the interrupt
    rd(0, OFS_MSR, q);
    rd(1, OFS_MSR, q);
    wr(0, OFS_IER, 8'h00);
    wr(1, OFS_IER, 8'h08);
    RI_N = 2'h0;
    tick(5);
    check(IRQ, 1'b1);
    RI_N = 2'h1;
    tick(5);
    check(IRQ, 1'b1);
    rd(0, OFS_MSR, q);
    check(q[2], 1'b1);
    RI_N = 2'h3;
    tick(5);
    check(IRQ, 1'b0);
    rd(0, OFS_ISR, q);
    check(q, ISR_NONE);
    rd(1, OFS_ISR, q);
    check(q, ISR_MODEM);
    rd(1, OFS_MSR, q);
    tick(3);
    check(IRQ, 1'b1);
    wr(0, OFS_MCR, 8'h02);
    wr(0, OFS_TCR, 8'h14);
    RX_LEVEL[6:0] = 7'h14;
    tick(4);
    check(RTS_N[0], 1'b0);
    wr(0, OFS_EFR, 8'h40);
    for (int i = 0; i < 5; i++) begin
      RX_LEVEL[6:0] = lv[i];
      tick(4);
      check(RTS_N[0], 5'h13 >> i & 5'h01);
    end
    RESET_N = 1'b0;
    tick(2);
    chk_reset();
    RESET_N = 1'b1;
    tick(3);
    rd(0, OFS_MCR, q);
    check(q, REG_RESET);
    results();
  end
  // the run needs well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    results();
  end
endmodule  // test_dual_uart_host_modem_pins
